// ==== hw/pcr_pkg.sv ====
// pcr_pkg: constants and carrier types for the panel configuration bank
// assumes a serial front end that turns frames into one-word accesses
package pcr_pkg;

  // register offsets (byte addresses)
  localparam logic [11:0] GREEN_SEED_OFF = 12'h414;
  localparam logic [11:0] MOD_INDEX_OFF  = 12'h418;
  localparam logic [11:0] MOD_DATA_OFF   = 12'h41c;
  localparam logic [11:0] MEM_CTRL_OFF   = 12'h420;
  localparam logic [11:0] DTH_ADDR_OFF   = 12'h424;
  localparam logic [11:0] DTH_DATA_OFF   = 12'h428;
  localparam logic [11:0] SIGNATURE_OFF  = 12'h42c;
  localparam logic [11:0] DEV_IDENT_OFF  = 12'h430;
  localparam logic [11:0] PIN_DATA_OFF   = 12'h434;
  localparam logic [11:0] PIN_CTRL_OFF   = 12'h438;
  localparam logic [11:0] RED_SEED_OFF   = 12'h43c;

  // widths and depths
  localparam int SEED_W      = 15;
  localparam int MOD_DEPTH   = 32;
  localparam int MOD_INDEX_W = 6;
  localparam int DTH_AW      = 6;
  localparam int DTH_DEPTH   = 64;
  localparam int PIN_N       = 8;
  localparam int PIX_W       = 18;

  // pin control field positions
  localparam int PIN_TYPE_LSB = 0;
  localparam int PIN_MODE_LSB = 8;

  // reset values
  localparam logic [31:0] ZERO_RST     = 32'h0000_0000;
  localparam logic [31:0] MEM_CTRL_RST = 32'h1ef8_0008;
  localparam logic [31:0] PIN_RST      = 32'h0000_0000;
  // arbitrary neutral identity value
  localparam logic [31:0] DEV_IDENT_DEF = 32'h0a5a_0001;

  // signature generator
  localparam logic [31:0] SIG_POLY = 32'h04c1_1db7;
  localparam logic [31:0] SIG_INIT = 32'hffff_ffff;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pcr_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } pcr_rsp_t;

  typedef struct packed {
    logic             frame_start;
    logic             valid;
    logic [PIX_W-1:0] data;
  } pcr_pix_t;

endpackage : pcr_pkg

// ==== hw/pcr_regs.sv ====
// pcr_regs: configuration register bank of the flat panel controller
// assumes a serial front end delivering one-word accesses on sys_clk
`timescale 1ns/1ps
module pcr_regs
  import pcr_pkg::*;
#(
  parameter logic [31:0] DEV_IDENT = DEV_IDENT_DEF
)
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // register access from the serial front end
  input  wire pcr_req_t              req,
  output pcr_rsp_t                   rsp,
  // pixel stream and signature enable
  input  wire pcr_pix_t              pix,
  input  wire logic                  sig_enable,
  // configuration to the panel datapath
  output logic [SEED_W-1:0]          green_seed,
  output logic [SEED_W-1:0]          red_seed,
  output logic [31:0]                mem_ctrl,
  // modulation memory read port for the datapath
  input  wire logic [4:0]            mod_rd_entry,
  output logic [63:0]                mod_rd_data,
  // dither ram read port for the datapath
  input  wire logic [DTH_AW-1:0]     dth_rd_addr,
  output logic [31:0]                dth_rd_data,
  // general purpose pins
  input  wire logic [PIN_N-1:0]      pin_i,
  output logic [PIN_N-1:0]           pin_o,
  output logic [PIN_N-1:0]           pin_oe_n,
  output logic [PIN_N-1:0]           pin_pull_en,
  output logic [PIN_N-1:0]           pin_pull_up
);

  // storage
  logic [63:0]             mod_mem [MOD_DEPTH];
  logic [31:0]             dth_mem [DTH_DEPTH];

  logic [SEED_W-1:0]       green_seed_reg;
  logic [SEED_W-1:0]       red_seed_reg;
  logic [MOD_INDEX_W-1:0]  mod_index_reg;
  logic [31:0]             mem_ctrl_reg;
  logic [DTH_AW-1:0]       dth_addr_reg;
  logic [DTH_AW-1:0]       dth_addr_next;
  logic [DTH_DEPTH-1:0]    dth_vld_reg;
  logic [31:0]             sig_reg;
  logic [PIN_N-1:0]        pin_out_reg;
  logic [PIN_N-1:0]        pin_type_reg;
  logic [PIN_N-1:0]        pin_mode_reg;
  pcr_rsp_t                rsp_reg;

  // access decode
  logic                    wr;
  logic                    rd;
  logic                    hit;
  logic [4:0]              mod_entry;
  logic                    mod_high;
  logic                    sig_valid;
  logic [31:0]             sig_value;

  assign wr        = req.valid && req.write;
  assign rd        = req.valid && !req.write;
  assign mod_entry = mod_index_reg[5:1];
  assign mod_high  = mod_index_reg[0];

  // only the word offsets of the bank are mapped
  always_comb
  begin
    case (req.addr)
      GREEN_SEED_OFF, MOD_INDEX_OFF, MOD_DATA_OFF, MEM_CTRL_OFF,
      DTH_ADDR_OFF, DTH_DATA_OFF, SIGNATURE_OFF, DEV_IDENT_OFF,
      PIN_DATA_OFF, PIN_CTRL_OFF, RED_SEED_OFF: hit = 1'b1;
      default:                                  hit = 1'b0;
    endcase
  end

  // seeds
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      green_seed_reg <= ZERO_RST[SEED_W-1:0];
      red_seed_reg   <= ZERO_RST[SEED_W-1:0];
    end
    else if (wr)
    begin
      if (req.addr == GREEN_SEED_OFF)
      begin
        green_seed_reg <= req.wdata[SEED_W-1:0];
      end
      if (req.addr == RED_SEED_OFF)
      begin
        red_seed_reg <= req.wdata[SEED_W-1:0];
      end
    end
  end

  // modulation memory index and data
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mod_index_reg <= ZERO_RST[MOD_INDEX_W-1:0];
    end
    else if (wr && req.addr == MOD_INDEX_OFF)
    begin
      mod_index_reg <= req.wdata[MOD_INDEX_W-1:0];
    end
  end

  // index bit 0 picks the low or high word of the 64-bit entry
  always_ff @(posedge sys_clk)
  begin
    if (wr && req.addr == MOD_DATA_OFF)
    begin
      if (mod_high)
      begin
        mod_mem[mod_entry][63:32] <= req.wdata;
      end
      else
      begin
        mod_mem[mod_entry][31:0] <= req.wdata;
      end
    end
  end

  // datapath read port, one cycle behind the entry select
  always_ff @(posedge sys_clk)
  begin
    mod_rd_data <= mod_mem[mod_rd_entry];
  end

  // memory type and controller settings
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mem_ctrl_reg <= MEM_CTRL_RST;
    end
    else if (wr && req.addr == MEM_CTRL_OFF)
    begin
      mem_ctrl_reg <= req.wdata;
    end
  end

  // dither ram address counter
  always_comb
  begin
    dth_addr_next = dth_addr_reg;
    if (wr && req.addr == DTH_ADDR_OFF)
    begin
      dth_addr_next = req.wdata[DTH_AW-1:0];
    end
    else if (req.valid && req.addr == DTH_DATA_OFF)
    begin
      dth_addr_next = dth_addr_reg + DTH_AW'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dth_addr_reg <= ZERO_RST[DTH_AW-1:0];
    end
    else
    begin
      dth_addr_reg <= dth_addr_next;
    end
  end

  // dither ram contents
  always_ff @(posedge sys_clk)
  begin
    if (wr && req.addr == DTH_DATA_OFF)
    begin
      dth_mem[dth_addr_reg] <= req.wdata;
    end
  end

  // written flags: a word never written reads as the reset value
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dth_vld_reg <= '0;
    end
    else if (wr && req.addr == DTH_DATA_OFF)
    begin
      dth_vld_reg[dth_addr_reg] <= 1'b1;
    end
  end

  // datapath port, masked the same way
  always_ff @(posedge sys_clk)
  begin
    if (dth_vld_reg[dth_rd_addr])
    begin
      dth_rd_data <= dth_mem[dth_rd_addr];
    end
    else
    begin
      dth_rd_data <= ZERO_RST;
    end
  end

  // signature generator and its register
  pcr_sig u_sig (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (sig_enable),
    .pix       (pix),
    .sig_valid (sig_valid),
    .sig_value (sig_value)
  );

  // a captured signature wins over a software write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sig_reg <= ZERO_RST;
    end
    else if (sig_valid)
    begin
      sig_reg <= sig_value;
    end
    else if (wr && req.addr == SIGNATURE_OFF)
    begin
      sig_reg <= req.wdata;
    end
  end

  // pin data and control
  // control word: type bits pick output, mode bits pick the weak pull
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_out_reg  <= PIN_RST[PIN_N-1:0];
      pin_type_reg <= PIN_RST[PIN_TYPE_LSB +: PIN_N];
      pin_mode_reg <= PIN_RST[PIN_MODE_LSB +: PIN_N];
    end
    else if (wr)
    begin
      if (req.addr == PIN_DATA_OFF)
      begin
        pin_out_reg <= req.wdata[PIN_N-1:0];
      end
      if (req.addr == PIN_CTRL_OFF)
      begin
        pin_type_reg <= req.wdata[PIN_TYPE_LSB +: PIN_N];
        pin_mode_reg <= req.wdata[PIN_MODE_LSB +: PIN_N];
      end
    end
  end

  // weak mode: pin left undriven, pull follows the data bit
  for (genvar g = 0; g < PIN_N; g++)
  begin : g_pin
    always_comb
    begin
      pin_o[g]       = pin_out_reg[g];
      pin_pull_en[g] = pin_type_reg[g] && pin_mode_reg[g];
      pin_pull_up[g] = pin_out_reg[g];
      pin_oe_n[g]    = !(pin_type_reg[g] && !pin_mode_reg[g]);
    end
  end

  // response one cycle after every host access
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rsp_reg <= '0;
    end
    else
    begin
      rsp_reg.ack   <= req.valid;
      // unmapped or misaligned offsets are refused and read as zero
      rsp_reg.err   <= req.valid && !hit;
      rsp_reg.rdata <= ZERO_RST;
      if (rd)
      begin
        case (req.addr)
          GREEN_SEED_OFF:
            rsp_reg.rdata <= {17'h0_0000, green_seed_reg};
          RED_SEED_OFF:
            rsp_reg.rdata <= {17'h0_0000, red_seed_reg};
          MOD_INDEX_OFF:
            rsp_reg.rdata <= {26'h000_0000, mod_index_reg};
          MOD_DATA_OFF:
            rsp_reg.rdata <= mod_high ? mod_mem[mod_entry][63:32]
                                      : mod_mem[mod_entry][31:0];
          MEM_CTRL_OFF:
            rsp_reg.rdata <= mem_ctrl_reg;
          DTH_ADDR_OFF:
            rsp_reg.rdata <= {26'h000_0000, dth_addr_reg};
          DTH_DATA_OFF:
            rsp_reg.rdata <= dth_vld_reg[dth_addr_reg]
                             ? dth_mem[dth_addr_reg] : ZERO_RST;
          SIGNATURE_OFF:
            rsp_reg.rdata <= sig_reg;
          DEV_IDENT_OFF:
            rsp_reg.rdata <= DEV_IDENT;
          PIN_DATA_OFF:
            rsp_reg.rdata <= {24'h00_0000, pin_i};
          PIN_CTRL_OFF:
            rsp_reg.rdata <= {16'h0000, pin_mode_reg, pin_type_reg};
          default:
            rsp_reg.rdata <= ZERO_RST;
        endcase
      end
    end
  end

  // configuration outputs come straight from their registers
  assign rsp        = rsp_reg;
  assign green_seed = green_seed_reg;
  assign red_seed   = red_seed_reg;
  assign mem_ctrl   = mem_ctrl_reg;

endmodule : pcr_regs

// ==== hw/pcr_sig.sv ====
// pcr_sig: running signature over the panel pixel stream
// assumes pixel stream and frame start are synchronous to sys_clk
`timescale 1ns/1ps
module pcr_sig
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // control and stream
  input  wire logic        enable,
  input  wire pcr_pix_t    pix,
  // result
  output logic             sig_valid,
  output logic [31:0]      sig_value
);

  logic [31:0] crc_reg;
  logic        armed_reg;

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [PIX_W-1:0] d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = PIX_W - 1; i >= 0; i--)
    begin
      fb = r[31] ^ d[i];
      r  = {r[30:0], 1'b0} ^ (fb ? SIG_POLY : 32'h0000_0000);
    end
    return r;
  endfunction : crc_step

  // a frame start closes the previous frame and restarts the sum
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      crc_reg   <= SIG_INIT;
      armed_reg <= 1'b0;
    end
    else if (pix.frame_start)
    begin
      crc_reg   <= SIG_INIT;
      armed_reg <= enable;
    end
    else if (pix.valid && enable && armed_reg)
    begin
      crc_reg <= crc_step(crc_reg, pix.data);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sig_valid <= 1'b0;
      sig_value <= ZERO_RST;
    end
    else
    begin
      sig_valid <= pix.frame_start && armed_reg && enable;
      if (pix.frame_start && armed_reg && enable)
      begin
        sig_value <= crc_reg;
      end
    end
  end

endmodule : pcr_sig

// ==== test/panel_controller_config_regs_tb_top.sv ====
// panel_controller_config_regs_tb_top: directed bench of pcr_regs
// assumes pcr_host_model drives req and the bench drives the rest
`timescale 1ns/1ps
module panel_controller_config_regs_tb_top;
  import pcr_pkg::*;
  logic              sys_clk, rst_n, sig_enable;
  pcr_req_t          req;
  pcr_rsp_t          rsp, r;
  pcr_pix_t          pix;
  logic [SEED_W-1:0] green_seed, red_seed;
  logic [31:0]       mem_ctrl, dth_rd_data;
  logic [4:0]        mod_rd_entry;
  logic [63:0]       mod_rd_data;
  logic [DTH_AW-1:0] dth_rd_addr;
  logic [PIN_N-1:0]  pin_i, pin_o, pin_oe_n, pin_pull_en, pin_pull_up;
  int                bad_count, n_checks, cyc;

  pcr_regs dut_u (.sys_clk, .rst_n, .req, .rsp, .pix, .sig_enable,
    .green_seed, .red_seed, .mem_ctrl, .mod_rd_entry, .mod_rd_data,
    .dth_rd_addr, .dth_rd_data, .pin_i, .pin_o, .pin_oe_n, .pin_pull_en,
    .pin_pull_up);
  pcr_host_model host_u (.sys_clk, .req, .rsp);

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [63:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r);
    chk("write answer", 64'h2, {r.ack, r.err});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0, r);
    chk($sformatf("read %h", a), {30'h0, 2'h2, e}, {30'h0, r.ack, r.err,
        r.rdata});
  endtask : rd
  task automatic pulse(input logic fs, v, input logic [PIX_W-1:0] d);
    @(posedge sys_clk) #1;
    pix = '{fs, v, d};
    @(posedge sys_clk) #1;
    pix = '{1'b0, 1'b0, ~d};
  endtask : pulse
  function automatic logic [31:0] crc18(input logic [PIX_W-1:0] d);
    logic [31:0] c;
    c = SIG_INIT;
    for (int i = PIX_W - 1; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? SIG_POLY : 32'h0);
    return c;
  endfunction : crc18
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // hang guard, some 35 times the expected run of about 84 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      test_done;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    sig_enable = 1'b0;
    pix = '0;
    pin_i = 8'ha5;
    mod_rd_entry = 5'h0;
    dth_rd_addr = 6'h0;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    rd(GREEN_SEED_OFF, ZERO_RST);
    rd(MOD_INDEX_OFF, ZERO_RST);
    rd(DTH_ADDR_OFF, ZERO_RST);
    rd(MEM_CTRL_OFF, MEM_CTRL_RST);
    $display("test reset done");
    wr(GREEN_SEED_OFF, 32'h0000_7fff);
    wr(RED_SEED_OFF, 32'h0000_2aaa);
    chk("green_seed", 64'h7fff, green_seed);
    chk("red_seed", 64'h2aaa, red_seed);
    rd(RED_SEED_OFF, 32'h0000_2aaa);
    wr(MEM_CTRL_OFF, 32'h0000_0008);
    rd(MEM_CTRL_OFF, 32'h0000_0008);
    chk("mem_ctrl", 64'h8, mem_ctrl);
    $display("test seeds done");
    wr(DEV_IDENT_OFF, 32'hffff_ffff);
    rd(DEV_IDENT_OFF, DEV_IDENT_DEF);
    host_u.xfer(1'b0, 12'h440, 32'h0, r);
    chk("unmapped", 64'h3_0000_0000, {r.ack, r.err, r.rdata});
    $display("test ident done");
    wr(DTH_ADDR_OFF, 32'h0000_003f);
    wr(DTH_DATA_OFF, 32'h1234_5678);
    wr(DTH_DATA_OFF, 32'h9abc_def0);
    rd(DTH_ADDR_OFF, 32'h0000_0001);
    wr(DTH_ADDR_OFF, 32'h0000_003f);
    rd(DTH_DATA_OFF, 32'h1234_5678);
    rd(DTH_DATA_OFF, 32'h9abc_def0);
    repeat (2) @(posedge sys_clk);
    chk("dth_rd_data", 64'h9abc_def0, dth_rd_data);
    $display("test dither done");
    wr(MOD_INDEX_OFF, 32'h0000_0004);
    wr(MOD_DATA_OFF, 32'h1111_2222);
    wr(MOD_INDEX_OFF, 32'h0000_0005);
    wr(MOD_DATA_OFF, 32'h3333_4444);
    wr(MOD_INDEX_OFF, 32'h0000_0004);
    rd(MOD_DATA_OFF, 32'h1111_2222);
    mod_rd_entry = 5'h2;
    repeat (2) @(posedge sys_clk);
    chk("mod_rd_data", 64'h3333_4444_1111_2222, mod_rd_data);
    $display("test modulation done");
    wr(PIN_CTRL_OFF, 32'h0000_0203);
    chk("pin_oe_n", 64'hfe, pin_oe_n);
    chk("pin_pull_en", 64'h02, pin_pull_en);
    wr(PIN_DATA_OFF, 32'h0000_0081);
    chk("pin_o", 64'h81, pin_o);
    chk("pin_pull_up", 64'h81, pin_pull_up);
    rd(PIN_DATA_OFF, 32'h0000_00a5);
    $display("test pins done");
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    rd(GREEN_SEED_OFF, ZERO_RST);
    rd(MEM_CTRL_OFF, MEM_CTRL_RST);
    rd(DTH_DATA_OFF, ZERO_RST);
    chk("green_seed after reset", 64'h0, green_seed);
    chk("dth_rd_data after reset", 64'h0, dth_rd_data);
    chk("pin_oe_n after reset", 64'hff, pin_oe_n);
    $display("test reset again done");
    sig_enable = 1'b1;
    pulse(1'b1, 1'b0, 18'h0);
    pulse(1'b0, 1'b1, 18'h2a5c3);
    pulse(1'b1, 1'b0, 18'h0);
    repeat (3) @(posedge sys_clk);
    rd(SIGNATURE_OFF, crc18(18'h2a5c3));
    $display("test signature done");
    test_done;
  end
endmodule : panel_controller_config_regs_tb_top

// ==== test/pcr_host_model.sv ====
// pcr_host_model: host master issuing one-word register accesses
// assumes the bench calls xfer and owns every other input
`timescale 1ns/1ps
module pcr_host_model
  import pcr_pkg::*;
(
  // clock
  input  wire logic     sys_clk,
  // register access
  output pcr_req_t      req,
  input  wire pcr_rsp_t rsp
);
  initial req = '0;
  // request stands for one taking edge, answer read just after that same edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output pcr_rsp_t r);
    @(posedge sys_clk) #1;
    req = '{1'b1, wr, a, wd};
    @(posedge sys_clk) #1;
    // released lines show inverted junk, not the last value
    req = '{1'b0, ~wr, ~a, ~wd};
    r = rsp;
  endtask : xfer
endmodule : pcr_host_model

// ==== test/pcr_regs_chk.sv ====
// pcr_regs_chk: port-level checks of the panel configuration bank
// assumes it is bound into pcr_regs and sees only that module's ports
`timescale 1ns/1ps
module pcr_regs_chk
  import pcr_pkg::*;
#(
  parameter logic [31:0] DEV_IDENT = DEV_IDENT_DEF
)
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // register access
  input wire pcr_req_t          req,
  input wire pcr_rsp_t          rsp,
  // configuration and pins
  input wire logic [SEED_W-1:0] green_seed,
  input wire logic [SEED_W-1:0] red_seed,
  input wire logic [31:0]       mem_ctrl,
  input wire logic [PIN_N-1:0]  pin_i,
  input wire logic [PIN_N-1:0]  pin_oe_n,
  input wire logic [PIN_N-1:0]  pin_pull_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0]      wd_q;
  logic [PIN_N-1:0] pin_q;
  // inputs of the previous edge, for one-cycle answers
  always_ff @(posedge sys_clk)
  begin
    wd_q  <= req.wdata;
    pin_q <= pin_i;
  end
  property p_ack; req.valid |=> rsp.ack; endproperty
  a_ack: assert property (p_ack)
    else $error("access not answered");
  property p_idle; !req.valid |=> !rsp.ack; endproperty
  a_idle: assert property (p_idle)
    else $error("answer without access");
  property p_unmapped;
    req.valid && (req.addr < 12'h414 || req.addr > 12'h43c)
      |=> rsp.err && rsp.rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_green;
    req.valid && req.write && req.addr == GREEN_SEED_OFF
      |=> green_seed == wd_q[SEED_W-1:0];
  endproperty
  a_green: assert property (p_green)
    else $error("green seed not loaded");
  property p_red;
    req.valid && req.write && req.addr == RED_SEED_OFF
      |=> red_seed == wd_q[SEED_W-1:0];
  endproperty
  a_red: assert property (p_red)
    else $error("red seed not loaded");
  property p_memrst;
    $rose(rst_n) |-> mem_ctrl == MEM_CTRL_RST && green_seed == '0;
  endproperty
  a_memrst: assert property (p_memrst)
    else $error("reset values wrong");
  property p_ident;
    req.valid && !req.write && req.addr == DEV_IDENT_OFF
      |=> rsp.rdata == DEV_IDENT && !rsp.err;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identity read wrong");
  property p_pinctl;
    req.valid && req.write && req.addr == PIN_CTRL_OFF
      |=> pin_oe_n == ~(wd_q[7:0] & ~wd_q[15:8])
          && pin_pull_en == (wd_q[7:0] & wd_q[15:8]);
  endproperty
  a_pinctl: assert property (p_pinctl)
    else $error("pin control not applied");
  property p_pinrd;
    req.valid && !req.write && req.addr == PIN_DATA_OFF
      |=> rsp.rdata[PIN_N-1:0] == pin_q;
  endproperty
  a_pinrd: assert property (p_pinrd)
    else $error("pin levels not read");
endmodule : pcr_regs_chk

bind pcr_regs pcr_regs_chk #(.DEV_IDENT(DEV_IDENT)) chk_u (.sys_clk, .rst_n,
  .req, .rsp, .green_seed, .red_seed, .mem_ctrl, .pin_i, .pin_oe_n,
  .pin_pull_en);
